/* File: core/ssl_defs.vh */
// Purpose: Constants for the serial slave link supervisor
// Assumes: 100 MHz core clock
// Notes: Times are given in their own unit and converted to cycles here
`ifndef SSL_DEFS_VH
`define SSL_DEFS_VH
`define SSL_CLK_HZ 100000000
`define SSL_STATION_MIN 6'h01
`define SSL_STATION_MAX 6'h20
`define SSL_MODE_RTU 1'h0
`define SSL_MODE_ASCII 1'h1
`define SSL_BAUD_4800 2'h0
`define SSL_BAUD_9600 2'h1
`define SSL_BAUD_19200 2'h2
`define SSL_BAUD_38400 2'h3
// Bit dividers are clock cycles per bit at 100 MHz, sized to the divider register
`define SSL_DIV_4800 16'h5161
`define SSL_DIV_9600 16'h28B0
`define SSL_DIV_19200 16'h1458
`define SSL_DIV_38400 16'h0A2C
`define SSL_PAR_NONE 2'h0
`define SSL_PAR_EVEN 2'h1
`define SSL_PAR_ODD 2'h2
`define SSL_TICK_MS 100
`define SSL_TICK_CYC (`SSL_CLK_HZ / 1000 * `SSL_TICK_MS)
`define SSL_WAIT_UNIT_MS 2
`define SSL_WAIT_UNIT_CYC (`SSL_CLK_HZ / 1000 * `SSL_WAIT_UNIT_MS)
`define SSL_WAIT_MIN 7'h05
`define SSL_WAIT_MAX 7'h41
`define SSL_RETRY_MAX 5'h14
`define SSL_ACT_DEC1 2'h0
`define SSL_ACT_COAST 2'h1
`define SSL_ACT_DEC2 2'h2
`define SSL_ACT_RUN 2'h3
`endif

/* File: core/ssl_link_supervisor.v */
// Purpose: Serial slave link: character framing, address filter, timeout and retry supervision
// Assumes: Frame decode (RTU/ASCII) is outside; this block frames characters and supervises
// Notes: Tick and wait-unit counts are parameters so a simulation can shorten them; bit dividers are fixed
`include "ssl_defs.vh"
`default_nettype none
module ssl_link_supervisor #(
  parameter TICK_CYC = `SSL_TICK_CYC,
  parameter WAIT_UNIT_CYC = `SSL_WAIT_UNIT_CYC
) (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Configuration
  input wire [5:0] stationNumber,
  input wire frameMode,
  input wire [1:0] baudSelect,
  input wire stopBitSelect,
  input wire [1:0] paritySelect,
  input wire dataFormat,
  input wire [7:0] timeoutTenths,
  input wire [1:0] timeoutAction,
  input wire [4:0] retryLimit,
  input wire [6:0] turnaroundUnits,
  // Serial pins
  input wire rxd,
  output reg txd,
  output reg txEnable,
  // Frame decoder side
  output reg [7:0] rxData,
  output reg rxValid,
  output reg rxParityError,
  output wire modeAscii,
  input wire frameDone,
  input wire [7:0] frameAddress,
  input wire frameCrcOk,
  input wire frameIsPoll,
  output reg frameAccept,
  // Response side
  input wire [7:0] txData,
  input wire txValid,
  output wire txReady,
  // Supervision status
  output reg comm_timeout_indication,
  output reg retry_limit_fault,
  output reg stopDec1,
  output reg stopDec2,
  output reg stopCoast
);
  localparam ST_IDLE = 4'h1;
  localparam ST_WAIT = 4'h2;
  localparam ST_SEND = 4'h4;
  localparam ST_DONE = 4'h8;

  reg [1:0] baudLatched;
  reg baudCaught;
  reg [15:0] bitDiv;
  reg [15:0] rxCnt;
  reg [3:0] rxBit;
  reg rxBusy;
  reg [10:0] rxShift;
  reg rxdPrev;
  reg [15:0] txCnt;
  reg [3:0] txBit;
  reg [11:0] txShift;
  reg [3:0] txLen;
  reg [3:0] txState;
  reg [23:0] waitCnt;
  reg [6:0] waitUnits;
  reg [23:0] tickCnt;
  reg [7:0] tenths;
  reg [4:0] errCount;
  wire [3:0] dataBits = dataFormat ? 4'h7 : 4'h8;
  wire parityOn = (paritySelect != `SSL_PAR_NONE);
  wire [3:0] rxFrameBits = dataBits + {3'h0, parityOn};
  wire [6:0] waitTarget = (turnaroundUnits < `SSL_WAIT_MIN) ? `SSL_WAIT_MIN :
    (turnaroundUnits > `SSL_WAIT_MAX) ? `SSL_WAIT_MAX : turnaroundUnits;
  wire [4:0] limitEff = (retryLimit > `SSL_RETRY_MAX) ? `SSL_RETRY_MAX : retryLimit;
  wire stationOk = (stationNumber >= `SSL_STATION_MIN) && (stationNumber <= `SSL_STATION_MAX);
  wire addrMatch = stationOk && (frameAddress == {2'h0, stationNumber});
  wire [7:0] txMasked = dataFormat ? {1'h0, txData[6:0]} : txData;
  wire txPar = (^txMasked) ^ (paritySelect == `SSL_PAR_ODD);

  assign modeAscii = frameMode;
  assign txReady = (txState == ST_WAIT || txState == ST_IDLE) && waitUnits >= waitTarget;

  // Rate is caught once after reset release so later changes wait for the next reset
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      baudLatched <= `SSL_BAUD_9600;
      baudCaught <= 1'b0;
    end else if (!baudCaught) begin
      baudLatched <= baudSelect;
      baudCaught <= 1'b1;
    end
  end

  always @* begin
    case (baudLatched)
      `SSL_BAUD_4800: bitDiv = `SSL_DIV_4800;
      `SSL_BAUD_9600: bitDiv = `SSL_DIV_9600;
      `SSL_BAUD_19200: bitDiv = `SSL_DIV_19200;
      default: bitDiv = `SSL_DIV_38400;
    endcase
  end

  // Receiver: samples mid-bit, start plus data plus optional parity
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxdPrev <= 1'b1;
      rxBusy <= 1'b0;
      rxCnt <= 16'h0000;
      rxBit <= 4'h0;
      rxShift <= 11'h000;
      rxData <= 8'h00;
      rxValid <= 1'b0;
      rxParityError <= 1'b0;
    end else begin
      rxdPrev <= rxd;
      rxValid <= 1'b0;
      if (!rxBusy) begin
        if (rxdPrev && !rxd) begin
          rxBusy <= 1'b1;
          rxCnt <= {1'b0, bitDiv[15:1]};
          rxBit <= 4'h0;
        end
      end else if (rxCnt != 16'h0000) begin
        rxCnt <= rxCnt - 16'h0001;
      end else begin
        rxCnt <= bitDiv - 16'h0001;
        rxBit <= rxBit + 4'h1;
        if (rxBit == 4'h0) begin
          if (rxd)
            rxBusy <= 1'b0;
        end else if (rxBit <= rxFrameBits) begin
          rxShift <= {rxd, rxShift[10:1]};
        end else begin
          // Stop bit reached; second stop bit is not checked on receive
          rxBusy <= 1'b0;
          rxValid <= 1'b1;
          if (parityOn) begin
            rxData <= dataFormat ? {1'b0, rxShift[9:3]} : rxShift[9:2];
            rxParityError <= (^(dataFormat ? rxShift[10:3] : rxShift[10:2])) ^
              (paritySelect == `SSL_PAR_ODD);
          end else begin
            rxData <= dataFormat ? {1'b0, rxShift[10:4]} : rxShift[10:3];
            rxParityError <= 1'b0;
          end
        end
      end
    end
  end

  // Frame supervision: address filter, retry counter, poll timeout
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      frameAccept <= 1'b0;
      errCount <= 5'h00;
      retry_limit_fault <= 1'b0;
      comm_timeout_indication <= 1'b0;
      tickCnt <= 24'h000000;
      tenths <= 8'h00;
    end else begin
      frameAccept <= frameDone && addrMatch && frameCrcOk;
      if (frameDone && addrMatch && !frameCrcOk) begin
        if (errCount + 5'h01 >= limitEff)
          retry_limit_fault <= 1'b1;
        errCount <= errCount + 5'h01;
      end else if (frameDone && addrMatch) begin
        errCount <= 5'h00;
      end
      if (timeoutTenths == 8'h00) begin
        tickCnt <= 24'h000000;
        tenths <= 8'h00;
      end else if (frameDone && addrMatch && frameCrcOk && frameIsPoll) begin
        tickCnt <= 24'h000000;
        tenths <= 8'h00;
      end else if (tickCnt == TICK_CYC - 1) begin
        tickCnt <= 24'h000000;
        if (tenths != 8'hFF)
          tenths <= tenths + 8'h01;
        if (tenths + 8'h01 >= timeoutTenths)
          comm_timeout_indication <= 1'b1;
      end else begin
        tickCnt <= tickCnt + 24'h000001;
      end
    end
  end

  // Stop commands; retry fault takes the decel-1 stop as its stop setting
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stopDec1 <= 1'b0;
      stopDec2 <= 1'b0;
      stopCoast <= 1'b0;
    end else begin
      stopDec1 <= retry_limit_fault ||
        (comm_timeout_indication && timeoutAction == `SSL_ACT_DEC1);
      stopCoast <= comm_timeout_indication && timeoutAction == `SSL_ACT_COAST;
      stopDec2 <= comm_timeout_indication && timeoutAction == `SSL_ACT_DEC2;
    end
  end

  // Transmitter with turnaround wait measured from the last accepted frame
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      txState <= ST_IDLE;
      waitCnt <= 24'h000000;
      waitUnits <= 7'h00;
      txCnt <= 16'h0000;
      txBit <= 4'h0;
      txShift <= 12'hFFF;
      txLen <= 4'h0;
      txd <= 1'b1;
      txEnable <= 1'b0;
    end else begin
      if (frameAccept) begin
        waitCnt <= 24'h000000;
        waitUnits <= 7'h00;
      end else if (waitUnits < waitTarget) begin
        if (waitCnt == WAIT_UNIT_CYC - 1) begin
          waitCnt <= 24'h000000;
          waitUnits <= waitUnits + 7'h01;
        end else begin
          waitCnt <= waitCnt + 24'h000001;
        end
      end
      case (txState)
        ST_IDLE, ST_WAIT: begin
          txEnable <= 1'b0;
          txd <= 1'b1;
          txState <= frameAccept ? ST_WAIT : txState;
          if (txValid && txReady && !frameAccept) begin
            txState <= ST_SEND;
            txEnable <= 1'b1;
            txShift <= dataFormat ?
              {2'h3, parityOn ? txPar : 1'b1, txMasked[6:0], 1'b0, 1'b1} :
              {1'b1, parityOn ? txPar : 1'b1, txMasked, 1'b0, 1'b1};
            txLen <= 4'h1 + dataBits + {3'h0, parityOn} + (stopBitSelect ? 4'h2 : 4'h1);
            txBit <= 4'h0;
            txCnt <= 16'h0000;
          end
        end
        ST_SEND: begin
          if (txCnt != 16'h0000) begin
            txCnt <= txCnt - 16'h0001;
          end else if (txBit == txLen) begin
            txState <= ST_DONE;
          end else begin
            txd <= txShift[1];
            txShift <= {1'b1, txShift[11:1]};
            txBit <= txBit + 4'h1;
            txCnt <= bitDiv - 16'h0001;
          end
        end
        ST_DONE: begin
          // Drop enable on the same edge that enters IDLE so ready never overlaps a sending flag
          txState <= ST_IDLE;
          txd <= 1'b1;
          txEnable <= 1'b0;
        end
        default: txState <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: testbench/ssl_link_monitor.sv */
// Purpose: Port checker for the link supervisor
// Assumes: One clock
// Notes: Stop outputs follow the flags by a cycle
`default_nettype none
module ssl_link_monitor (
  // Clock and settings
  input wire core_clk,
  input wire reset_n,
  input wire [5:0] stationNumber,
  input wire frameMode,
  input wire [1:0] timeoutAction,
  input wire [7:0] timeoutTenths,
  // Frames and serial
  input wire frameDone,
  input wire [7:0] frameAddress,
  input wire frameCrcOk,
  input wire frameAccept,
  input wire modeAscii,
  input wire txd,
  input wire txEnable,
  input wire txReady,
  // Status
  input wire comm_timeout_indication,
  input wire retry_limit_fault,
  input wire stopDec1,
  input wire stopDec2,
  input wire stopCoast
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_hit;
    frameDone && frameCrcOk && frameAddress == {2'h0, stationNumber}
      && stationNumber - 6'h01 < 6'h20;
  endsequence
  sequence s_tmo(logic [1:0] act);
    $rose(comm_timeout_indication) && timeoutAction == act;
  endsequence
  a_accept_hit:
    assert property (s_hit |=> frameAccept) else $error("frame not accepted");
  a_accept_only:
    assert property (frameAccept |-> $past(frameDone && frameAddress == {2'h0, stationNumber}))
      else $error("stray accept");
  a_mode_follow:
    assert property (modeAscii == frameMode) else $error("mode differs");
  a_tx_start:
    assert property ($rose(txEnable) |-> txd ##1 !txd) else $error("bad start bit");
  a_ready_busy:
    assert property (txEnable |-> !txReady) else $error("ready while sending");
  a_tmo_off:
    assert property ($rose(comm_timeout_indication) |-> $past(timeoutTenths) != 8'h00)
      else $error("timeout while off");
  a_tmo_hold:
    assert property (comm_timeout_indication |=> comm_timeout_indication) else $error("flag lost");
  a_tmo_dec1:
    assert property (s_tmo(2'h0) |=> stopDec1) else $error("no dec1 stop");
  a_tmo_coast:
    assert property (s_tmo(2'h1) |=> stopCoast) else $error("no coast stop");
  a_tmo_dec2:
    assert property (s_tmo(2'h2) |=> stopDec2) else $error("no dec2 stop");
  a_fault_stop:
    assert property ($rose(retry_limit_fault) |=> stopDec1) else $error("no fault stop");
endmodule
bind ssl_link_supervisor ssl_link_monitor i_monitor (.*);
`default_nettype wire

/* File: testbench/ssl_master_model.sv */
// Purpose: Master controller on the serial pins
// Assumes: Eight data bits, even parity, one stop
// Notes: Line rests high between characters
`default_nettype none
module ssl_master_model #(
  parameter int BITC = 2604
) (
  // Serial pins
  output logic rxd,
  input wire logic txd,
  input wire logic txEnable,
  // Last character heard
  output logic [9:0] gotFrame,
  output var int gotCnt
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic sendChar(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'h1, ^d ^ bad, d, 1'h0};
    for (int i = 0; i < 11; i++) begin
      rxd = f[i];
      #(BITC * 10);
    end
  endtask
  initial begin
    rxd = 1'h1;
    gotCnt = 0;
    forever begin
      @(negedge txd iff txEnable);
      #(BITC * 15);
      for (int i = 0; i < 10; i++) begin
        gotFrame[i] = txd;
        #(BITC * 10);
      end
      gotCnt++;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the link supervisor
// Assumes: Tick 10 cycles, wait unit 20 cycles
// Notes: Serial traffic is slow, so one character crosses each way
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BITC = 100000000 / 38400;
  logic core_clk, reset_n, frameMode, stopBitSelect, dataFormat, rxd, txd, txEnable;
  logic rxValid, rxParityError, modeAscii, frameDone, frameCrcOk, frameIsPoll, frameAccept;
  logic txValid, txReady, comm_timeout_indication, retry_limit_fault, stopDec1, stopDec2;
  logic stopCoast, flt, bad;
  logic [1:0] baudSelect, paritySelect, timeoutAction;
  logic [4:0] retryLimit;
  logic [5:0] stationNumber;
  logic [6:0] turnaroundUnits;
  logic [7:0] timeoutTenths, frameAddress, rxData, txData, d;
  logic [9:0] gotFrame;
  int gotCnt, errCnt, n, errorCnt = 0, checksDone = 0;
  ssl_link_supervisor #(.TICK_CYC(10), .WAIT_UNIT_CYC(20)) i_dut (.*);
  ssl_master_model #(.BITC(BITC)) i_master (.*);
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic printVerdict;
    if (errorCnt == 0 && checksDone > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask
  task automatic rst;
    reset_n = 1'h0;
    repeat (5) step;
    reset_n = 1'h1;
    {errCnt, flt} = 0;
    repeat (2) step;
  endtask
  task automatic frame(input logic [7:0] a, input logic ok);
    logic hit;
    hit = a == {2'h0, stationNumber};
    {frameAddress, frameCrcOk, frameIsPoll, frameDone} = {a, ok, 2'h3};
    step;
    frameDone = 1'h0;
    if (hit) errCnt = ok ? 0 : errCnt + 1;
    flt = flt | (hit && !ok && errCnt >= retryLimit);
    chk(frameAccept, hit && ok);
    repeat (2) step;
    chk(retry_limit_fault, flt);
  endtask
  initial begin
    // Span of the slowest path: two characters plus slack
    #900000;
    errorCnt++;
    printVerdict;
  end
  initial begin
    void'($urandom(32'h95466636));
    {reset_n, frameMode, stopBitSelect, dataFormat, frameDone, txValid} = 6'h00;
    {frameCrcOk, frameIsPoll, frameAddress, txData, timeoutTenths, timeoutAction} = 0;
    {paritySelect, baudSelect, turnaroundUnits} = {2'h1, 2'h3, 7'h05};
    stationNumber = 6'($urandom_range(1, 32));
    retryLimit = 5'($urandom_range(0, 3));
    rst;
    repeat (30) begin
      frameMode = 1'($urandom);
      n = $urandom_range(0, 40);
      frame($urandom_range(0, 2) ? {2'h0, stationNumber} : 8'(n), $urandom_range(0, 3) != 0);
    end
    for (int i = 0; i < 5; i++) begin
      timeoutAction = 2'(i);
      timeoutTenths = i < 4 ? 8'h04 : 8'h00;
      rst;
      repeat (15) step;
      frame({2'h0, stationNumber}, 1'h1);
      repeat (12) step;
      chk(comm_timeout_indication, 0);
      repeat (40) step;
      chk({comm_timeout_indication, stopDec1, stopCoast, stopDec2},
          i == 4 ? 4'h0 : {1'h1, i == 0, i == 1, i == 2});
    end
    d = 8'($urandom);
    bad = 1'($urandom);
    fork i_master.sendChar(d, bad); join_none
    n = 0;
    do begin step; n++; end while (rxValid !== 1'h1 && n < 40000);
    chk({rxParityError, rxData}, {bad, d});
    repeat (2 * BITC) step;
    baudSelect = 2'h0;
    frame({2'h0, stationNumber}, 1'h1);
    {txData, txValid} = {d, 1'h1};
    n = 2;
    while (txReady !== 1'h1 && n < 400) begin step; n++; end
    chk(n >= 95 && n <= 105, 1);
    step;
    txValid = 1'h0;
    n = 0;
    while (gotCnt == 0 && n < 40000) begin step; n++; end
    chk(gotFrame, {1'h1, ^d, d});
    printVerdict;
  end
endmodule
`default_nettype wire
